/* File: design/fpe_defs.svh */
// Constants of the flash program/erase controller: offsets, fields, keys.
// Assumes APB byte addresses; included by design/fpe_ctrl.sv.
//
// How it works
// - flash reads stall until program/erase finishes
// - control writes ignored while locked, except reload
// - two key words in order unlock control
// - wrong key locks controller until reset
// - wrong key answers with bus error
// - writing lock bit relocks the controller
// - half-word write programs 16 bits there
// - non-half-word program write gets bus error
// - program only erased cells; zero always allowed
// - protected program or page-erase target skips and flags protection error
// - success sets end flag; software clears it
// - register writes ignored while busy
// - page erase via select, address, start
// - busy visible one cycle after start
// - mass erase clears main pages only
// - option area holds exactly eight bytes
// - option keys set option write enable
// - option program needs erased byte, else error
// - high byte is complement of low byte
// - unprotecting read option mass-erases main first
// - option erase via select then start
// - erased read-protection byte means protected
// - each protection bit covers two pages
// - main memory is 32 pages of 2K
`ifndef FPE_DEFS_SVH
`define FPE_DEFS_SVH
`define FPE_FIRST_UNLOCK_WORD      32'h45670123
`define FPE_SECOND_UNLOCK_WORD      32'hCDEF89AB
`define FPE_OFF_KEY   8'h04
`define FPE_OFF_OKEY  8'h08
`define FPE_OFF_SR    8'h0C
`define FPE_OFF_CR    8'h10
`define FPE_OFF_AR    8'h14
`define FPE_OFF_OBR   8'h1C
`define FPE_OFF_WRPR  8'h20
`define FPE_SR_BUSY   0
`define FPE_SR_NERR   2
`define FPE_SR_WPERR  4
`define FPE_SR_EOP    5
`define FPE_CR_PG     0
`define FPE_CR_PER    1
`define FPE_CR_MER    2
`define FPE_CR_OPTION_PROGRAM_ENABLE  4
`define FPE_CR_OPTION_ERASE_SELECT  5
`define FPE_CR_START_TRIGGER   6
`define FPE_CR_LOCK   7
`define FPE_CR_OPTION_WRITE_ENABLED 9
`define FPE_CR_RELOAD 13
`define FPE_ERASED    16'hFFFF
`define FPE_RDP_OPEN  8'hAA
`define FPE_OPT_RST   8'hFF
`define FPE_PG_HI     15
`define FPE_PG_LO     11
`endif

/* File: design/fpe_pkg.sv */
// Types of the flash program/erase controller.
// Assumes nothing outside itself.
package fpe_pkg;
	typedef enum logic [2:0] {
		FPE_IDLE  = 3'h0,
		FPE_CHECK = 3'h1,
		FPE_EXEC  = 3'h3,
		FPE_AUTO  = 3'h2,
		FPE_READ  = 3'h6,
		FPE_LOAD  = 3'h4
	} fpe_state_t;
	typedef enum logic [2:0] {
		FPE_OP_READ  = 3'h0,
		FPE_OP_PROG  = 3'h1,
		FPE_OP_PAGE  = 3'h2,
		FPE_OP_MASS  = 3'h3,
		FPE_OP_OREAD = 3'h4,
		FPE_OP_OPROG = 3'h5,
		FPE_OP_OERAS = 3'h6
	} fpe_op_t;
	typedef struct packed {
		fpe_op_t     op;
		logic [15:0] addr;
		logic [15:0] data;
	} fpe_fa_t;
	typedef struct packed {
		fpe_state_t     state;
		logic           fa_req;
		fpe_fa_t        fa;
		logic           pready;
		logic [31:0]    prdata;
		logic           pslverr;
		logic           mem_ready;
		logic           mem_err;
		logic [15:0]    mem_rdata;
		logic           kstage;
		logic           okstage;
		logic           lockout;
		logic           locked;
		logic           pg, page_erase_select, mass_erase_select, option_program_enable, option_erase_select, option_write_enabled;
		logic           busy, nerr, wperr, eop;
		logic [31:0]    ar;
		logic [7:0][7:0] opt;
		logic [2:0]     cnt;
		logic [15:0]    op_data;
	} fpe_st_t;
endpackage

/* File: design/fpe_ctrl.sv */
// Flash program/erase controller: APB registers, CPU flash port, array port.
// Assumes the array acks each request with a one-cycle fa_ack.
//
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "fpe_defs.svh"
module fpe_ctrl (
	input  wire logic              clock,
	input  wire logic              rst_n,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic                   pready,
	output logic [31:0]            prdata,
	output logic                   pslverr,
	input  wire logic              mem_valid,
	input  wire logic              mem_write,
	input  wire logic              mem_opt,
	input  wire logic [1:0]        mem_size,
	input  wire logic [15:0]       mem_addr,
	input  wire logic [15:0]       mem_wdata,
	output logic                   mem_ready,
	output logic                   mem_err,
	output logic [15:0]            mem_rdata,
	output logic                   fa_req,
	output fpe_pkg::fpe_fa_t       fa_cmd,
	input  wire logic              fa_ack,
	input  wire logic [15:0]       fa_rdata
);
	fpe_pkg::fpe_st_t st_r;
	fpe_pkg::fpe_st_t st_nxt;

	//----------------------------------------
	// decode helpers
	//----------------------------------------
	logic        setup;
	logic        wr;
	logic        kbad;
	logic [15:0] wrp;
	logic        rdp_prot;
	logic [31:0] sr_val;
	logic [31:0] cr_val;

	assign setup = psel & ~penable;
	assign wr = psel & penable & st_r.pready & pwrite & ~st_r.busy;
	assign kbad = st_r.lockout | (st_r.kstage ? pwdata != `FPE_SECOND_UNLOCK_WORD : pwdata != `FPE_FIRST_UNLOCK_WORD);
	assign wrp = {st_r.opt[7], st_r.opt[6]};
	assign rdp_prot = st_r.opt[0] != `FPE_RDP_OPEN;

	always_comb begin
		sr_val = 32'h0;
		sr_val[`FPE_SR_BUSY] = st_r.busy;
		sr_val[`FPE_SR_NERR] = st_r.nerr;
		sr_val[`FPE_SR_WPERR] = st_r.wperr;
		sr_val[`FPE_SR_EOP] = st_r.eop;
		cr_val = 32'h0;
		cr_val[`FPE_CR_PG] = st_r.pg;
		cr_val[`FPE_CR_PER] = st_r.page_erase_select;
		cr_val[`FPE_CR_MER] = st_r.mass_erase_select;
		cr_val[`FPE_CR_OPTION_PROGRAM_ENABLE] = st_r.option_program_enable;
		cr_val[`FPE_CR_OPTION_ERASE_SELECT] = st_r.option_erase_select;
		cr_val[`FPE_CR_LOCK] = st_r.locked;
		cr_val[`FPE_CR_OPTION_WRITE_ENABLED] = st_r.option_write_enabled;
	end

	//----------------------------------------
	// next state
	//----------------------------------------
	always_comb begin
		st_nxt = st_r;
		st_nxt.pready = 1'b0;
		st_nxt.mem_ready = 1'b0;
		st_nxt.mem_err = 1'b0;
		// answer prepared during the setup cycle
		if (setup) begin
			st_nxt.pready = 1'b1;
			st_nxt.pslverr = 1'b0;
			case (paddr)
				`FPE_OFF_KEY: begin
					st_nxt.prdata = 32'h0;
					st_nxt.pslverr = pwrite & st_r.locked & kbad;
				end
				`FPE_OFF_OKEY: st_nxt.prdata = 32'h0;
				`FPE_OFF_SR: st_nxt.prdata = sr_val;
				`FPE_OFF_CR: st_nxt.prdata = cr_val;
				`FPE_OFF_AR: st_nxt.prdata = st_r.ar;
				`FPE_OFF_OBR: st_nxt.prdata = {st_r.opt[3], st_r.opt[2], st_r.opt[1], st_r.opt[0]};
				`FPE_OFF_WRPR: st_nxt.prdata = {st_r.opt[7], st_r.opt[6], st_r.opt[5], st_r.opt[4]};
				default: begin
					st_nxt.prdata = 32'h0;
					st_nxt.pslverr = 1'b1;
				end
			endcase
		end
		// register writes take effect at the access edge
		if (wr) begin
			case (paddr)
				`FPE_OFF_KEY: begin
					if (st_r.locked && !st_r.lockout) begin
						if (kbad) begin
							st_nxt.lockout = 1'b1;
						end else if (st_r.kstage) begin
							st_nxt.locked = 1'b0;
							st_nxt.kstage = 1'b0;
						end else begin
							st_nxt.kstage = 1'b1;
						end
					end
				end
				`FPE_OFF_OKEY: begin
					if (!st_r.locked) begin
						if (pwdata != (st_r.okstage ? `FPE_SECOND_UNLOCK_WORD : `FPE_FIRST_UNLOCK_WORD)) begin
							st_nxt.okstage = 1'b0;
						end else if (st_r.okstage) begin
							st_nxt.option_write_enabled = 1'b1;
							st_nxt.okstage = 1'b0;
						end else begin
							st_nxt.okstage = 1'b1;
						end
					end
				end
				`FPE_OFF_SR: begin
					if (pwdata[`FPE_SR_NERR]) begin
						st_nxt.nerr = 1'b0;
					end
					if (pwdata[`FPE_SR_WPERR]) begin
						st_nxt.wperr = 1'b0;
					end
					if (pwdata[`FPE_SR_EOP]) begin
						st_nxt.eop = 1'b0;
					end
				end
				`FPE_OFF_CR: begin
					if (!st_r.locked) begin
						st_nxt.pg = pwdata[`FPE_CR_PG];
						st_nxt.page_erase_select = pwdata[`FPE_CR_PER];
						st_nxt.mass_erase_select = pwdata[`FPE_CR_MER];
						st_nxt.option_program_enable = pwdata[`FPE_CR_OPTION_PROGRAM_ENABLE];
						st_nxt.option_erase_select = pwdata[`FPE_CR_OPTION_ERASE_SELECT];
						if (!pwdata[`FPE_CR_OPTION_WRITE_ENABLED]) begin
							st_nxt.option_write_enabled = 1'b0;
						end
						if (pwdata[`FPE_CR_LOCK]) begin
							st_nxt.locked = 1'b1;
							st_nxt.option_write_enabled = 1'b0;
							st_nxt.kstage = 1'b0;
						end
					end
					if (st_r.state == fpe_pkg::FPE_IDLE) begin
						if (pwdata[`FPE_CR_RELOAD]) begin
							st_nxt.state = fpe_pkg::FPE_LOAD;
							st_nxt.cnt = 3'h0;
							st_nxt.fa_req = 1'b1;
							st_nxt.fa = '{fpe_pkg::FPE_OP_OREAD, 16'h0, 16'h0};
						end else if (!st_r.locked && pwdata[`FPE_CR_START_TRIGGER]) begin
							if (pwdata[`FPE_CR_MER]) begin
								st_nxt.state = fpe_pkg::FPE_EXEC;
								st_nxt.busy = 1'b1;
								st_nxt.fa_req = 1'b1;
								st_nxt.fa = '{fpe_pkg::FPE_OP_MASS, 16'h0, 16'h0};
							end else if (pwdata[`FPE_CR_PER]) begin
								if (!wrp[st_r.ar[`FPE_PG_HI:`FPE_PG_LO+1]]) begin
									st_nxt.wperr = 1'b1;
								end else begin
									st_nxt.state = fpe_pkg::FPE_EXEC;
									st_nxt.busy = 1'b1;
									st_nxt.fa_req = 1'b1;
									st_nxt.fa = '{fpe_pkg::FPE_OP_PAGE,
										{st_r.ar[`FPE_PG_HI:`FPE_PG_LO], 11'h0}, 16'h0};
								end
							end else if (pwdata[`FPE_CR_OPTION_ERASE_SELECT] && st_r.option_write_enabled) begin
								st_nxt.state = fpe_pkg::FPE_EXEC;
								st_nxt.busy = 1'b1;
								st_nxt.fa_req = 1'b1;
								st_nxt.fa = '{fpe_pkg::FPE_OP_OERAS, 16'h0, 16'h0};
							end
						end
					end
				end
				`FPE_OFF_AR: begin
					if (!st_r.locked) begin
						st_nxt.ar = pwdata;
					end
				end
				default: ;
			endcase
		end
		// array sequencer
		case (st_r.state)
			fpe_pkg::FPE_IDLE: begin
				if (st_nxt.state == fpe_pkg::FPE_IDLE && mem_valid && !st_r.mem_ready) begin
					st_nxt.mem_ready = 1'b1;
					if (!mem_write) begin
						st_nxt.mem_ready = 1'b0;
						st_nxt.state = fpe_pkg::FPE_READ;
						st_nxt.fa_req = 1'b1;
						st_nxt.fa = '{mem_opt ? fpe_pkg::FPE_OP_OREAD : fpe_pkg::FPE_OP_READ,
							mem_addr, 16'h0};
					end else if (mem_opt ? !(st_r.option_program_enable && st_r.option_write_enabled) : !st_r.pg) begin
						st_nxt.mem_err = 1'b1;
					end else if (mem_size != 2'h1) begin
						st_nxt.mem_err = 1'b1;
					end else if (!mem_opt && !wrp[mem_addr[`FPE_PG_HI:`FPE_PG_LO+1]]) begin
						st_nxt.wperr = 1'b1;
					end else begin
						st_nxt.state = fpe_pkg::FPE_CHECK;
						st_nxt.busy = 1'b1;
						st_nxt.fa_req = 1'b1;
						st_nxt.fa = '{mem_opt ? fpe_pkg::FPE_OP_OREAD : fpe_pkg::FPE_OP_READ,
							mem_addr, 16'h0};
						st_nxt.op_data = mem_opt ? {~mem_wdata[7:0], mem_wdata[7:0]}
							: mem_wdata;
					end
				end
			end
			fpe_pkg::FPE_READ: begin
				if (fa_ack) begin
					st_nxt.fa_req = 1'b0;
					st_nxt.mem_ready = 1'b1;
					st_nxt.mem_rdata = fa_rdata;
					st_nxt.state = fpe_pkg::FPE_IDLE;
				end
			end
			fpe_pkg::FPE_CHECK: begin
				if (fa_ack) begin
					st_nxt.fa_req = 1'b0;
					st_nxt.state = fpe_pkg::FPE_IDLE;
					st_nxt.busy = 1'b0;
					if (st_r.fa.op == fpe_pkg::FPE_OP_OREAD) begin
						if (fa_rdata != `FPE_ERASED) begin
							st_nxt.wperr = 1'b1;
						end else if (st_r.fa.addr[3:1] == 3'h0 && rdp_prot
							&& st_r.op_data[7:0] == `FPE_RDP_OPEN) begin
							st_nxt.state = fpe_pkg::FPE_AUTO;
							st_nxt.busy = 1'b1;
							st_nxt.fa_req = 1'b1;
							st_nxt.fa = '{fpe_pkg::FPE_OP_MASS, 16'h0, 16'h0};
						end else begin
							st_nxt.state = fpe_pkg::FPE_EXEC;
							st_nxt.busy = 1'b1;
							st_nxt.fa_req = 1'b1;
							st_nxt.fa = '{fpe_pkg::FPE_OP_OPROG, st_r.fa.addr, st_r.op_data};
						end
					end else if (fa_rdata != `FPE_ERASED && st_r.op_data != 16'h0) begin
						st_nxt.nerr = 1'b1;
					end else begin
						st_nxt.state = fpe_pkg::FPE_EXEC;
						st_nxt.busy = 1'b1;
						st_nxt.fa_req = 1'b1;
						st_nxt.fa = '{fpe_pkg::FPE_OP_PROG, st_r.fa.addr, st_r.op_data};
					end
				end
			end
			fpe_pkg::FPE_AUTO: begin
				if (fa_ack) begin
					st_nxt.state = fpe_pkg::FPE_EXEC;
					st_nxt.fa = '{fpe_pkg::FPE_OP_OPROG, st_r.fa.addr, st_r.op_data};
				end
			end
			fpe_pkg::FPE_EXEC: begin
				if (fa_ack) begin
					st_nxt.fa_req = 1'b0;
					st_nxt.state = fpe_pkg::FPE_IDLE;
					st_nxt.busy = 1'b0;
					st_nxt.eop = 1'b1;
				end
			end
			fpe_pkg::FPE_LOAD: begin
				if (fa_ack) begin
					st_nxt.opt[st_r.cnt] = fa_rdata[7:0];
					st_nxt.cnt = st_r.cnt + 3'h1;
					st_nxt.fa.addr = {12'h0, st_r.cnt + 3'h1, 1'b0};
					if (st_r.cnt == 3'h7) begin
						st_nxt.fa_req = 1'b0;
						st_nxt.state = fpe_pkg::FPE_IDLE;
					end
				end
			end
			default: st_nxt.state = fpe_pkg::FPE_IDLE;
		endcase
	end

	//----------------------------------------
	// state register; options load after reset
	//----------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '0;
			st_r.state <= fpe_pkg::FPE_LOAD;
			st_r.fa_req <= 1'b1;
			st_r.fa.op <= fpe_pkg::FPE_OP_OREAD;
			st_r.locked <= 1'b1;
			st_r.opt <= {8{`FPE_OPT_RST}};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign pready = st_r.pready;
	assign prdata = st_r.prdata;
	assign pslverr = st_r.pslverr;
	assign mem_ready = st_r.mem_ready;
	assign mem_err = st_r.mem_err;
	assign mem_rdata = st_r.mem_rdata;
	assign fa_req = st_r.fa_req;
	assign fa_cmd = st_r.fa;

	//----------------------------------------
	// checks
	//----------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	AST_STALL: assert property (st_r.busy && $past(st_r.busy) |-> !mem_ready)
		else $error("flash port answered while busy");
	AST_CR_LOCKED: assert property (wr && paddr == `FPE_OFF_CR && st_r.locked
		|=> $stable(st_r.pg) && $stable(st_r.mass_erase_select))
		else $error("control changed while locked");
	AST_UNLOCK: assert property (wr && paddr == `FPE_OFF_KEY && st_r.locked
		&& !st_r.lockout && st_r.kstage && pwdata == `FPE_SECOND_UNLOCK_WORD |=> !st_r.locked)
		else $error("key pair did not unlock");
	AST_LOCKOUT: assert property (st_r.lockout |=> st_r.lockout && st_r.locked)
		else $error("lockout released");
	AST_KEYERR: assert property (setup && pwrite && paddr == `FPE_OFF_KEY
		&& st_r.locked && st_r.lockout |=> pready && pslverr)
		else $error("wrong key without bus error");
	AST_RELOCK: assert property (wr && paddr == `FPE_OFF_CR
		&& pwdata[`FPE_CR_LOCK] |=> st_r.locked && !st_r.option_write_enabled)
		else $error("lock bit did not relock");
	AST_SIZE: assert property (st_r.state == fpe_pkg::FPE_IDLE && !wr && mem_valid
		&& mem_write && !mem_opt && st_r.pg && mem_size != 2'h1 && !mem_ready
		|=> mem_ready && mem_err)
		else $error("bad size not refused");
	AST_BUSY: assert property (wr && paddr == `FPE_OFF_CR && !st_r.locked
		&& st_r.state == fpe_pkg::FPE_IDLE && pwdata[`FPE_CR_START_TRIGGER] && pwdata[`FPE_CR_MER]
		&& !pwdata[`FPE_CR_RELOAD] |=> st_r.busy ##1 st_r.busy)
		else $error("busy not raised after start");
	AST_EOP: assert property (st_r.state == fpe_pkg::FPE_EXEC && fa_ack
		|=> st_r.eop && !st_r.busy && !fa_req)
		else $error("end flag not set on completion");
endmodule
`default_nettype wire

/* File: dv/fpe_array_model.sv */
// Behavioural flash array facing the program/erase controller.
// Assumes one command at a time, held on fa_req until fa_ack.
`timescale 1ns/10ps
`default_nettype none
module fpe_array_model #(
	parameter int DELAY = 3
) (
	input  wire logic             clock,
	input  wire logic             rst_n,
	input  wire logic             fa_req,
	input  wire fpe_pkg::fpe_fa_t fa_cmd,
	output logic                  fa_ack,
	output logic [15:0]           fa_rdata
);
	logic [15:0] mem [32768];
	logic [15:0] opt [8];
	logic [15:0] last_odata;
	int          cnt;

	initial begin
		foreach (mem[i]) mem[i] = 16'hFFFF;
		foreach (opt[i]) opt[i] = 16'hFFFF;
	end

	// ----------------------------------------
	// slow answer; data line toggles when idle
	// ----------------------------------------
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			fa_ack <= 1'h0;
			fa_rdata <= 16'h0;
			cnt <= 0;
		end else if (fa_ack || !fa_req || cnt < DELAY) begin
			fa_ack <= 1'h0;
			fa_rdata <= ~fa_rdata;
			cnt <= (fa_req && !fa_ack) ? cnt + 1 : 0;
		end else begin
			fa_ack <= 1'h1;
			cnt <= 0;
			case (fa_cmd.op)
				fpe_pkg::FPE_OP_READ: fa_rdata <= mem[fa_cmd.addr[15:1]];
				fpe_pkg::FPE_OP_PROG: mem[fa_cmd.addr[15:1]] <= fa_cmd.data;
				fpe_pkg::FPE_OP_PAGE:
					for (int i = 0; i < 1024; i++)
						mem[{fa_cmd.addr[15:11], i[9:0]}] <= 16'hFFFF;
				fpe_pkg::FPE_OP_MASS: foreach (mem[i]) mem[i] <= 16'hFFFF;
				fpe_pkg::FPE_OP_OREAD: fa_rdata <= opt[fa_cmd.addr[3:1]];
				fpe_pkg::FPE_OP_OPROG: begin
					opt[fa_cmd.addr[3:1]] <= fa_cmd.data;
					last_odata <= fa_cmd.data;
				end
				fpe_pkg::FPE_OP_OERAS: foreach (opt[i]) opt[i] <= 16'hFFFF;
				default: fa_rdata <= ~fa_rdata;
			endcase
		end
	end
endmodule
`default_nettype wire

/* File: dv/tb.sv */
// Self-checking bench of the flash program/erase controller.
// Assumes the array model of dv/fpe_array_model.sv.
`timescale 1ns/10ps
`default_nettype none
`include "fpe_defs.svh"
module tb;
	logic             clock, rst_n, psel, penable, pwrite, pready, pslverr, e;
	logic [7:0]       paddr;
	logic [31:0]      pwdata, prdata, r;
	logic             mem_valid, mem_write, mem_opt, mem_ready, mem_err, fa_req, fa_ack;
	logic [1:0]       mem_size;
	logic [15:0]      mem_addr, mem_wdata, mem_rdata, fa_rdata, h;
	fpe_pkg::fpe_fa_t fa_cmd;
	int               error_cnt, comparisons;

	fpe_ctrl i_dut (.clock, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
		.prdata, .pslverr, .mem_valid, .mem_write, .mem_opt, .mem_size, .mem_addr,
		.mem_wdata, .mem_ready, .mem_err, .mem_rdata, .fa_req, .fa_cmd, .fa_ack, .fa_rdata);
	fpe_array_model i_arr (.clock, .rst_n, .fa_req, .fa_cmd, .fa_ack, .fa_rdata);

	initial begin
		clock = 1'h0;
		forever #5 clock = ~clock;
	end

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic give_verdict();
		$display("errors %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic hang();
		error_cnt++;
		give_verdict();
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clock);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'h1 && n < 50);
		if (n >= 50)
			hang();
		r = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	task automatic memx(input logic w, input logic [1:0] s, input logic o,
		input logic [15:0] a, input logic [15:0] d);
		int n;
		@(posedge clock);
		mem_valid <= 1'h1;
		mem_write <= w;
		mem_size <= s;
		mem_opt <= o;
		mem_addr <= a;
		mem_wdata <= d;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (mem_ready !== 1'h1 && n < 200);
		if (n >= 200)
			hang();
		h = mem_rdata;
		e = mem_err;
		mem_valid <= 1'h0;
	endtask

	task automatic idle();
		int n;
		n = 0;
		do begin
			apb(1'h0, `FPE_OFF_SR, 32'h0);
			n++;
		end while (r[0] !== 1'h0 && n < 100);
		if (n >= 100)
			hang();
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_lock();
		apb(1'h0, `FPE_OFF_OBR, 32'h0);
		chk("obr", r, 32'hFFFFFFFF);
		apb(1'h1, `FPE_OFF_CR, 32'h1);
		apb(1'h0, `FPE_OFF_CR, 32'h0);
		chk("cr_lock", {r[7], r[0]}, 32'h2);
		apb(1'h0, 8'h18, 32'h0);
		chk("unmapped", e, 32'h1);
		apb(1'h1, `FPE_OFF_KEY, `FPE_FIRST_UNLOCK_WORD);
		chk("first_unlock_word", e, 32'h0);
		apb(1'h1, `FPE_OFF_KEY, `FPE_SECOND_UNLOCK_WORD);
		apb(1'h1, `FPE_OFF_CR, 32'h1);
		apb(1'h0, `FPE_OFF_CR, 32'h0);
		chk("cr_open", {r[7], r[0]}, 32'h1);
	endtask

	task automatic t_prog();
		memx(1'h1, 2'h2, 1'h0, 16'h0100, 16'h1234);
		chk("word_err", e, 32'h1);
		memx(1'h1, 2'h1, 1'h0, 16'h0100, 16'h1234);
		chk("prog_err", e, 32'h0);
		idle();
		chk("sr_eop", r, 32'h20);
		memx(1'h1, 2'h1, 1'h0, 16'h0102, 16'hABCD);
		memx(1'h0, 2'h1, 1'h0, 16'h0102, 16'h0);
		chk("stalled_rd", h, 32'hABCD);
		memx(1'h0, 2'h1, 1'h0, 16'h0100, 16'h0);
		chk("prog_rd", h, 32'h1234);
		apb(1'h1, `FPE_OFF_SR, 32'h34);
		memx(1'h1, 2'h1, 1'h0, 16'h0100, 16'h5678);
		idle();
		chk("sr_nerr", r, 32'h4);
		apb(1'h1, `FPE_OFF_SR, 32'h34);
		memx(1'h1, 2'h1, 1'h0, 16'h0100, 16'h0000);
		idle();
		chk("sr_zero", r, 32'h20);
		memx(1'h0, 2'h1, 1'h0, 16'h0100, 16'h0);
		chk("zero_rd", h, 32'h0);
	endtask

	task automatic t_page();
		memx(1'h1, 2'h1, 1'h0, 16'h0900, 16'h1111);
		idle();
		apb(1'h1, `FPE_OFF_CR, 32'h2);
		apb(1'h1, `FPE_OFF_AR, 32'h0100);
		apb(1'h1, `FPE_OFF_CR, 32'h42);
		apb(1'h0, `FPE_OFF_SR, 32'h0);
		chk("busy", r[0], 32'h1);
		idle();
		chk("sr_page", r, 32'h20);
		memx(1'h0, 2'h1, 1'h0, 16'h0100, 16'h0);
		chk("page_rd", h, 32'hFFFF);
		memx(1'h0, 2'h1, 1'h0, 16'h0900, 16'h0);
		chk("next_page", h, 32'h1111);
		apb(1'h1, `FPE_OFF_SR, 32'h34);
	endtask

	task automatic t_option();
		apb(1'h1, `FPE_OFF_OKEY, `FPE_FIRST_UNLOCK_WORD);
		apb(1'h1, `FPE_OFF_OKEY, `FPE_SECOND_UNLOCK_WORD);
		apb(1'h0, `FPE_OFF_CR, 32'h0);
		chk("option_write_enabled", r[9], 32'h1);
		apb(1'h1, `FPE_OFF_CR, 32'h210);
		memx(1'h1, 2'h1, 1'h1, 16'h0004, 16'h0034);
		idle();
		chk("sr_opt", r, 32'h20);
		chk("opt_cmpl", i_arr.last_odata, 32'hCB34);
		apb(1'h1, `FPE_OFF_SR, 32'h34);
		memx(1'h1, 2'h1, 1'h1, 16'h0004, 16'h0012);
		idle();
		chk("sr_optbad", r, 32'h10);
		apb(1'h1, `FPE_OFF_SR, 32'h34);
		apb(1'h1, `FPE_OFF_CR, 32'h204);
		apb(1'h1, `FPE_OFF_CR, 32'h244);
		idle();
		memx(1'h0, 2'h1, 1'h0, 16'h0900, 16'h0);
		chk("mass_rd", h, 32'hFFFF);
	endtask

	task automatic t_protect();
		apb(1'h1, `FPE_OFF_SR, 32'h34);
		apb(1'h1, `FPE_OFF_CR, 32'h201);
		memx(1'h1, 2'h1, 1'h0, 16'h0900, 16'h2222);
		idle();
		apb(1'h1, `FPE_OFF_SR, 32'h34);
		apb(1'h1, `FPE_OFF_CR, 32'h220);
		apb(1'h1, `FPE_OFF_CR, 32'h260);
		idle();
		chk("sr_oerase", r, 32'h20);
		apb(1'h1, `FPE_OFF_SR, 32'h34);
		apb(1'h1, `FPE_OFF_CR, 32'h210);
		memx(1'h1, 2'h1, 1'h1, 16'h0000, 16'h00AA);
		idle();
		chk("sr_rdp", r, 32'h20);
		chk("rdp_cmpl", i_arr.last_odata, 32'h55AA);
		memx(1'h0, 2'h1, 1'h0, 16'h0900, 16'h0);
		chk("rdp_mass", h, 32'hFFFF);
		memx(1'h1, 2'h1, 1'h1, 16'h000C, 16'h00FE);
		idle();
		apb(1'h1, `FPE_OFF_SR, 32'h34);
		apb(1'h1, `FPE_OFF_CR, 32'h2000);
		// flash read stalls until the option reload is over
		memx(1'h0, 2'h1, 1'h0, 16'h0100, 16'h0);
		apb(1'h0, `FPE_OFF_WRPR, 32'h0);
		chk("wrpr", r, 32'hFFFEFFFF);
		apb(1'h0, `FPE_OFF_OBR, 32'h0);
		chk("obr_open", r, 32'hFFFFFFAA);
		apb(1'h1, `FPE_OFF_CR, 32'h1);
		memx(1'h1, 2'h1, 1'h0, 16'h0100, 16'h3333);
		chk("wp_ready", e, 32'h0);
		apb(1'h0, `FPE_OFF_SR, 32'h0);
		chk("sr_wperr", r, 32'h10);
		apb(1'h1, `FPE_OFF_SR, 32'h34);
		memx(1'h1, 2'h1, 1'h0, 16'h1000, 16'h4444);
		apb(1'h1, `FPE_OFF_AR, 32'h5555);
		idle();
		apb(1'h0, `FPE_OFF_AR, 32'h0);
		chk("ar_busy", r, 32'h100);
	endtask

	task automatic t_relock();
		apb(1'h1, `FPE_OFF_CR, 32'h80);
		apb(1'h1, `FPE_OFF_CR, 32'h1);
		apb(1'h0, `FPE_OFF_CR, 32'h0);
		chk("relock", {r[7], r[0]}, 32'h2);
		apb(1'h1, `FPE_OFF_KEY, 32'h0);
		chk("bad_key", e, 32'h1);
		apb(1'h1, `FPE_OFF_KEY, `FPE_FIRST_UNLOCK_WORD);
		chk("lockout", e, 32'h1);
		apb(1'h1, `FPE_OFF_KEY, `FPE_SECOND_UNLOCK_WORD);
		apb(1'h1, `FPE_OFF_CR, 32'h1);
		apb(1'h0, `FPE_OFF_CR, 32'h0);
		chk("still_lock", {r[7], r[0]}, 32'h2);
	endtask

	initial begin
		rst_n = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 8'h0;
		pwdata = 32'h0;
		mem_valid = 1'h0;
		mem_write = 1'h0;
		mem_opt = 1'h0;
		mem_size = 2'h1;
		mem_addr = 16'h0;
		mem_wdata = 16'h0;
		error_cnt = 0;
		comparisons = 0;
		repeat (4) @(posedge clock);
		rst_n <= 1'h1;
		t_lock();
		t_prog();
		t_page();
		t_option();
		t_protect();
		t_relock();
		give_verdict();
	end
endmodule
`default_nettype wire
